//--- src/hpc_top.sv
// hub port power switching, overcurrent, suspend and clock control with ahb-lite registers
//
// The register offsets and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ps
module hpc_top #(
	parameter int OC_CYCLES = hpc_pkg::OC_FILTER_CYCLES
) (
	input  wire logic                        hclk,
	input  wire logic                        hresetn,
	// ahb-lite slave
	input  wire logic                        hsel,
	input  wire logic [hpc_pkg::ADDR_W-1:0]  haddr,
	input  wire logic [1:0]                  htrans,
	input  wire logic                        hwrite,
	input  wire logic [2:0]                  hsize,
	input  wire logic [hpc_pkg::DATA_W-1:0]  hwdata,
	input  wire logic                        hready,
	output logic      [hpc_pkg::DATA_W-1:0]  hrdata,
	output logic                             hreadyout,
	output logic                             hresp,
	output logic                             irq,
	// pins
	input  wire logic                        overcurrent_n_port1,
	input  wire logic                        overcurrent_n_port2,
	input  wire logic                        overcurrent_n_port3,
	input  wire logic                        overcurrent_n_port4,
	output logic                             port_power_enable_n_port1,
	output logic                             port_power_enable_n_port2,
	output logic                             port_power_enable_n_port3,
	output logic                             port_power_enable_n_port4,
	output logic                             suspend_indicator,
	input  wire logic                        clock_rate_select,
	input  wire logic                        fast_clock_input,
	input  wire logic                        external_memory_disable,
	input  wire logic                        shared_power_select,
	output logic                             pll_enable,
	output logic                             fast_clock_select
);
	import hpc_pkg::*;

	// ************************************************************
	// declarations
	// ************************************************************
	logic [NUM_PORTS-1:0]  oc_n;
	logic [NUM_PORTS-1:0]  oc_level;
	logic [NUM_PORTS-1:0]  oc_rise;
	logic [NUM_PORTS-1:0]  pwr_req;
	logic [NUM_PORTS-1:0]  pwr_on;
	logic [NUM_PORTS-1:0]  next_pwr_en_n;
	logic [NUM_PORTS-1:0]  pwr_en_n;
	logic                  suspend_req;
	logic [EV_W-1:0]       event_st;
	logic [EV_W-1:0]       event_mask;
	logic [EV_W-1:0]       event_set;
	logic [EV_W-1:0]       event_clr;
	logic [EV_W-1:0]       next_event_st;
	logic                  cfg_ganged;
	hpc_strap_e            strap_state;
	logic                  strap_ganged;
	logic                  strap_fast;
	logic                  ganged;
	logic                  any_oc_level;
	logic                  any_oc_rise;
	logic                  fast_clk_prev;
	logic                  fast_clk_toggle;
	// bus
	logic                  addr_take;
	logic                  wr_pend;
	logic [7:0]            wr_ofs;
	logic [7:0]            rd_ofs;
	logic                  wr_ctrl;
	logic                  wr_event;
	logic                  wr_mask;
	logic                  wr_config;
	logic [DATA_W-1:0]     state_word;
	logic [DATA_W-1:0]     next_hrdata;

	// ************************************************************
	// overcurrent filtering
	// ************************************************************
	assign oc_n = {overcurrent_n_port4, overcurrent_n_port3, overcurrent_n_port2, overcurrent_n_port1};

	genvar gi;
	generate
		for (gi = 0; gi < NUM_PORTS; gi++) begin : g_oc
			hpc_oc_filter #(
				.CYCLES  (OC_CYCLES)
			) u_filter (
				.hclk     (hclk),
				.hresetn  (hresetn),
				.oc_n     (oc_n[gi]),
				.oc_level (oc_level[gi]),
				.oc_rise  (oc_rise[gi])
			);
		end
	endgenerate

	assign any_oc_level = |oc_level;
	assign any_oc_rise  = |oc_rise;

	// ************************************************************
	// strap capture after reset release
	// ************************************************************
	// straps are caught by a clocked process once reset is gone,
	// never loaded from a pin under the asynchronous reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			strap_state  <= HPC_STRAP_WAIT;
			strap_ganged <= 1'b0;
			strap_fast   <= 1'b0;
		end else begin
			case (strap_state)
				HPC_STRAP_WAIT: begin
					// shared power strap read only when the memory interface is off; clock rate strap always read
					strap_ganged <= external_memory_disable & shared_power_select;
					strap_fast   <= clock_rate_select;
					strap_state  <= HPC_STRAP_RUN;
				end
				HPC_STRAP_RUN: begin
					strap_state  <= HPC_STRAP_RUN;
				end
				default: begin
					strap_state  <= HPC_STRAP_WAIT;
				end
			endcase
		end
	end

	// with the memory interface active the pin carries data, so software chooses
	assign ganged = external_memory_disable ? strap_ganged : cfg_ganged;

	// ************************************************************
	// clock source selection
	// ************************************************************
	// pll runs from the crystal only in 6 MHz mode
	assign pll_enable        = (strap_state == HPC_STRAP_RUN) && !strap_fast;
	// the 48 MHz input path is picked by the strap
	assign fast_clock_select = (strap_state == HPC_STRAP_RUN) && strap_fast;

	// fast clock input must sit low in 6 MHz mode; a toggle seen there is flagged
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fast_clk_prev <= 1'b0;
		end else begin
			fast_clk_prev <= fast_clock_input;
		end
	end
	assign fast_clk_toggle = (strap_state == HPC_STRAP_RUN) && !strap_fast && fast_clock_input;

	// ************************************************************
	// port power
	// ************************************************************
	// per-port: a pending overcurrent event or live level drops only its own port
	// ganged: any overcurrent drops every port, all follow request bit 0
	always_comb begin
		for (int i = 0; i < NUM_PORTS; i++) begin
			if (ganged) begin
				pwr_on[i] = pwr_req[0] && !any_oc_level && !(|event_st[EV_OC_LO +: NUM_PORTS]);
			end else begin
				pwr_on[i] = pwr_req[i] && !oc_level[i] && !event_st[EV_OC_LO + i];
			end
		end
	end

	// active low, both levels driven from a flop
	assign next_pwr_en_n = ~pwr_on;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pwr_en_n          <= {NUM_PORTS{1'b1}};
			suspend_indicator <= 1'b0;
		end else begin
			pwr_en_n          <= next_pwr_en_n;
			suspend_indicator <= suspend_req;
		end
	end

	assign port_power_enable_n_port1 = pwr_en_n[0];
	assign port_power_enable_n_port2 = pwr_en_n[1];
	assign port_power_enable_n_port3 = pwr_en_n[2];
	assign port_power_enable_n_port4 = pwr_en_n[3];

	// ************************************************************
	// events and interrupt
	// ************************************************************
	assign event_set[EV_OC_LO +: NUM_PORTS] = ganged ? {NUM_PORTS{any_oc_rise}} : oc_rise;
	assign event_set[EV_CLKERR]             = fast_clk_toggle && !fast_clk_prev;
	assign event_clr                        = wr_event ? hwdata[EV_W-1:0] : '0;
	// a set in the clearing cycle wins
	assign next_event_st                    = (event_st & ~event_clr) | event_set;
	assign irq                              = |(event_st & event_mask);

	// ************************************************************
	// ahb-lite slave
	// ************************************************************
	assign hreadyout = 1'b1;
	assign hresp     = HRESP_OKAY;
	assign addr_take = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

	assign wr_ctrl   = wr_pend && (wr_ofs == OFS_CTRL);
	assign wr_event  = wr_pend && (wr_ofs == OFS_EVENT);
	assign wr_mask   = wr_pend && (wr_ofs == OFS_MASK);
	assign wr_config = wr_pend && (wr_ofs == OFS_CONFIG);

	assign rd_ofs    = haddr[7:0];

	assign state_word = {{(DATA_W - ST_PWR_LO - NUM_PORTS){1'b0}},
	                     ~pwr_en_n,
	                     pll_enable,
	                     suspend_indicator,
	                     strap_fast,
	                     ganged,
	                     oc_level};

	// unmapped offsets read as zero
	always_comb begin
		next_hrdata = '0;
		if (|haddr[ADDR_W-1:8]) begin
			next_hrdata = '0;
		end else if (rd_ofs == OFS_CTRL) begin
			next_hrdata = {{(DATA_W - CTRL_SUSPEND - 1){1'b0}}, suspend_req, pwr_req};
		end else if (rd_ofs == OFS_STATE) begin
			next_hrdata = state_word;
		end else if (rd_ofs == OFS_EVENT) begin
			next_hrdata = {{(DATA_W - EV_W){1'b0}}, event_st};
		end else if (rd_ofs == OFS_MASK) begin
			next_hrdata = {{(DATA_W - EV_W){1'b0}}, event_mask};
		end else if (rd_ofs == OFS_CONFIG) begin
			next_hrdata = {{(DATA_W - 1){1'b0}}, cfg_ganged};
		end
	end

	// address phase captured here, write data lands one edge later
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_ofs  <= 8'h00;
			hrdata  <= '0;
		end else begin
			wr_pend <= addr_take && hwrite && !(|haddr[ADDR_W-1:8]);
			wr_ofs  <= addr_take ? haddr[7:0] : wr_ofs;
			if (addr_take && !hwrite) begin
				hrdata <= next_hrdata;
			end
		end
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			// every register to its starting value
			pwr_req     <= CTRL_RESET[NUM_PORTS-1:0];
			suspend_req <= CTRL_RESET[CTRL_SUSPEND];
			event_st    <= EVENT_RESET;
			event_mask  <= MASK_RESET;
			cfg_ganged  <= CONFIG_RESET;
		end else begin
			event_st <= next_event_st;
			if (wr_ctrl) begin
				pwr_req     <= hwdata[CTRL_PWR_LO +: NUM_PORTS];
				suspend_req <= hwdata[CTRL_SUSPEND];
			end
			if (wr_mask) begin
				event_mask <= hwdata[EV_W-1:0];
			end
			if (wr_config) begin
				cfg_ganged <= hwdata[CFG_GANGED];
			end
		end
	end

endmodule

//--- src/hpc_pkg.sv
// constants for the hub port power and clock control block
package hpc_pkg;

	// ************************************************************
	// ports and bus
	// ************************************************************
	localparam int          NUM_PORTS  = 4;
	localparam int          DATA_W     = 32;
	localparam int          ADDR_W     = 32;
	localparam int          REG_IDX_LO = 2;
	localparam int          REG_IDX_W  = 3;

	// ************************************************************
	// register byte offsets
	// ************************************************************
	localparam logic [7:0]  OFS_CTRL   = 8'h00;
	localparam logic [7:0]  OFS_STATE  = 8'h04;
	localparam logic [7:0]  OFS_EVENT  = 8'h08;
	localparam logic [7:0]  OFS_MASK   = 8'h0c;
	localparam logic [7:0]  OFS_CONFIG = 8'h10;

	// ************************************************************
	// field positions
	// ************************************************************
	// ctrl: [3:0] port power request, [4] suspend request
	localparam int          CTRL_PWR_LO   = 0;
	localparam int          CTRL_SUSPEND  = 4;
	// state: [3:0] filtered overcurrent, [4] ganged, [5] 48 MHz input mode,
	// [6] suspended, [7] pll enabled, [11:8] power enabled per port
	localparam int          ST_OC_LO      = 0;
	localparam int          ST_GANGED     = 4;
	localparam int          ST_FAST       = 5;
	localparam int          ST_SUSPEND    = 6;
	localparam int          ST_PLL        = 7;
	localparam int          ST_PWR_LO     = 8;
	// event and mask: [3:0] overcurrent per port, [4] clock strap mismatch
	localparam int          EV_OC_LO      = 0;
	localparam int          EV_CLKERR     = 4;
	localparam int          EV_W          = 5;
	// config: [0] ganged mode when the memory interface owns the strap pin
	localparam int          CFG_GANGED    = 0;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [4:0]  CTRL_RESET    = 5'h00;
	localparam logic [4:0]  EVENT_RESET   = 5'h00;
	localparam logic [4:0]  MASK_RESET    = 5'h00;
	localparam logic        CONFIG_RESET  = 1'b0;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int          CLK_PERIOD_NS    = 5;
	localparam int          OC_FILTER_NS     = 1000;
	// least time, so round up
	localparam int          OC_FILTER_CYCLES = (OC_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ************************************************************
	// ahb encodings
	// ************************************************************
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0]  HTRANS_SEQ    = 2'h3;
	localparam logic        HRESP_OKAY    = 1'b0;

	typedef enum logic [1:0] {
		HPC_STRAP_WAIT,
		HPC_STRAP_RUN
	} hpc_strap_e;

endpackage

//--- src/hpc_oc_filter.sv
// glitch filter for one active-low overcurrent input
`timescale 1ns/1ps
module hpc_oc_filter #(
	parameter int CYCLES = hpc_pkg::OC_FILTER_CYCLES
) (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic oc_n,
	output logic      oc_level,
	output logic      oc_rise
);
	import hpc_pkg::*;

	localparam int                CNT_W   = $clog2(CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(CYCLES);
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

	logic [CNT_W-1:0] low_count;
	logic [CNT_W-1:0] next_low_count;
	logic             next_oc_level;

	// ************************************************************
	// low-time counter
	// ************************************************************
	// low means overcurrent
	// count consecutive low cycles, any high restarts
	assign next_low_count = oc_n ? '0 : ((low_count == CNT_MAX) ? low_count : low_count + CNT_ONE);
	// report only once the low has outlasted the filter
	assign next_oc_level  = !oc_n && (next_low_count == CNT_MAX);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			low_count <= '0;
			oc_level  <= 1'b0;
			oc_rise   <= 1'b0;
		end else begin
			low_count <= next_low_count;
			oc_level  <= next_oc_level;
			oc_rise   <= next_oc_level && !oc_level;
		end
	end

endmodule

//--- sim/hpc_checker.sv
// concurrent checks on the hub port power and clock control pins
`timescale 1ns/1ps
module hpc_checker #(
	parameter int OC_CYCLES = 4
) (
	input wire logic                       hclk,
	input wire logic                       hresetn,
	input wire logic                       hsel,
	input wire logic [hpc_pkg::ADDR_W-1:0] haddr,
	input wire logic [1:0]                 htrans,
	input wire logic                       hwrite,
	input wire logic [hpc_pkg::DATA_W-1:0] hwdata,
	input wire logic                       hready,
	input wire logic                       hreadyout,
	input wire logic                       hresp,
	input wire logic                       irq,
	input wire logic                       overcurrent_n_port1,
	input wire logic                       overcurrent_n_port2,
	input wire logic                       overcurrent_n_port3,
	input wire logic                       overcurrent_n_port4,
	input wire logic                       port_power_enable_n_port1,
	input wire logic                       port_power_enable_n_port2,
	input wire logic                       port_power_enable_n_port3,
	input wire logic                       port_power_enable_n_port4,
	input wire logic                       suspend_indicator,
	input wire logic                       clock_rate_select,
	input wire logic                       external_memory_disable,
	input wire logic                       shared_power_select,
	input wire logic                       pll_enable,
	input wire logic                       fast_clock_select
);
	import hpc_pkg::*;
	// filter count plus the power register stage: once power is off the sense
	// line goes high again, so a wider margin would never be reached
	localparam int SAT = OC_CYCLES + 1;
	logic [3:0] oc_n, pwr_n, long_low;
	logic [5:0] wr_hist;
	int         run [4];
	logic       addr_wr, per_port, gang_strap;
	assign oc_n = {overcurrent_n_port4, overcurrent_n_port3, overcurrent_n_port2, overcurrent_n_port1};
	assign pwr_n = {port_power_enable_n_port4, port_power_enable_n_port3,
		port_power_enable_n_port2, port_power_enable_n_port1};
	assign addr_wr = hsel && hready && htrans[1] && hwrite;
	assign per_port = external_memory_disable && !shared_power_select;
	assign gang_strap = external_memory_disable && shared_power_select;
	// ************************************************************
	// low run lengths, saturating so the counters stay small
	// ************************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_hist <= '0;
			long_low <= '0;
			for (int i = 0; i < 4; i++) run[i] <= 0;
		end else begin
			wr_hist <= {wr_hist[4:0], addr_wr};
			for (int i = 0; i < 4; i++) begin
				run[i] <= oc_n[i] ? 0 : ((run[i] < SAT) ? run[i] + 1 : SAT);
				if (!oc_n[i] && run[i] >= OC_CYCLES - 1) long_low[i] <= 1'b1;
			end
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	chk_pwr_after_rst: assert property ($rose(hresetn) |-> pwr_n == 4'hf)
		else $error("power enable not off after reset");
	chk_rst_outputs: assert property ($rose(hresetn) |-> !suspend_indicator && !irq && !pll_enable)
		else $error("outputs not at starting state after reset");
	chk_clk_mode: assert property ($past(hresetn) |-> pll_enable == !clock_rate_select
		&& fast_clock_select == clock_rate_select)
		else $error("clock source controls disagree with rate strap");
	chk_oc_bound: assert property (run[1] == SAT |-> port_power_enable_n_port2)
		else $error("port stays powered under long overcurrent");
	chk_gang_spread: assert property (gang_strap && run[3] == SAT |-> pwr_n == 4'hf)
		else $error("ganged overcurrent did not drop all ports");
	chk_port_isolate: assert property (per_port && wr_hist == 0 && $rose(port_power_enable_n_port1)
		|-> long_low[0])
		else $error("port dropped by another port overcurrent");
	chk_glitch_filter: assert property (wr_hist == 0 && $rose(port_power_enable_n_port1) |-> |long_low)
		else $error("port dropped without a filtered overcurrent");
	chk_suspend_follow: assert property (addr_wr && haddr == 32'(OFS_CTRL)
		|-> ##3 suspend_indicator == $past(hwdata[CTRL_SUSPEND], 2))
		else $error("suspend output does not follow request");
	chk_bus_okay: assert property (hreadyout && hresp == HRESP_OKAY)
		else $error("bus answer not ready and okay");
	cov_trip: cover property ($rose(port_power_enable_n_port1));
	cov_suspend: cover property ($rose(suspend_indicator));
	cov_irq: cover property ($rose(irq));
endmodule
bind hpc_top hpc_checker #(.OC_CYCLES(OC_CYCLES)) u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .irq(irq), .overcurrent_n_port1(overcurrent_n_port1), .overcurrent_n_port2(overcurrent_n_port2),
	.overcurrent_n_port3(overcurrent_n_port3), .overcurrent_n_port4(overcurrent_n_port4),
	.port_power_enable_n_port1(port_power_enable_n_port1), .port_power_enable_n_port2(port_power_enable_n_port2),
	.port_power_enable_n_port3(port_power_enable_n_port3), .port_power_enable_n_port4(port_power_enable_n_port4),
	.suspend_indicator(suspend_indicator), .clock_rate_select(clock_rate_select),
	.external_memory_disable(external_memory_disable), .shared_power_select(shared_power_select),
	.pll_enable(pll_enable), .fast_clock_select(fast_clock_select));

//--- sim/hpc_switch_model.sv
// load switch and current sense model for one downstream port
`timescale 1ns/1ps
module hpc_switch_model (
	input  wire logic power_en_n,
	input  wire logic load_fault,
	input  wire logic spike,
	output logic      oc_n
);
	// low enable feeds load, fault pulls sense low
	assign oc_n = !((load_fault && !power_en_n) || spike);
endmodule

//--- sim/hub_port_power_clock_control_tb.sv
// self-checking bench for the hub port power and clock control block
`timescale 1ns/1ps
module hub_port_power_clock_control_tb;
	import hpc_pkg::*;
	localparam int OCC = 4;
	logic        hclk = 0, hresetn = 0, hwrite = 0, fast_clock_input = 0;
	logic        clock_rate_select = 0, external_memory_disable = 1, shared_power_select = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
	logic [1:0]  htrans = 0;
	logic [3:0]  fault = 0, spike = 0, oc_n, pwr_n;
	logic [15:0] seed = 16'h2e50;
	logic        hready, hreadyout, hresp, irq, suspend_indicator, pll_enable, fast_clock_select;
	int          err_count = 0, comparisons = 0, cycles = 0;
	assign hready = hreadyout;
	hpc_top #(.OC_CYCLES(OCC)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .irq(irq), .overcurrent_n_port1(oc_n[0]), .overcurrent_n_port2(oc_n[1]),
		.overcurrent_n_port3(oc_n[2]), .overcurrent_n_port4(oc_n[3]), .port_power_enable_n_port1(pwr_n[0]),
		.port_power_enable_n_port2(pwr_n[1]), .port_power_enable_n_port3(pwr_n[2]),
		.port_power_enable_n_port4(pwr_n[3]), .suspend_indicator(suspend_indicator),
		.clock_rate_select(clock_rate_select), .fast_clock_input(fast_clock_input),
		.external_memory_disable(external_memory_disable), .shared_power_select(shared_power_select),
		.pll_enable(pll_enable), .fast_clock_select(fast_clock_select));
	for (genvar i = 0; i < 4; i++) begin : g_sw
		hpc_switch_model u_sw (.power_en_n(pwr_n[i]), .load_fault(fault[i]), .spike(spike[i]), .oc_n(oc_n[i]));
	end
	initial begin
		forever #2.5 hclk = ~hclk;
	end
	// ************************************************************
	// tasks and expectation functions
	// ************************************************************
	task automatic tally_and_finish;
		if (err_count == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	always @(posedge hclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_count++;
			tally_and_finish;
		end
	end
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	function automatic logic [31:0] st(input logic g, input logic f, input logic s, input logic [3:0] p);
		return {20'h0, p, !f, s, f, g, 4'h0};
	endfunction
	// one single transfer; read data is taken at the data-phase end edge
	task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
		@(posedge hclk);
		haddr <= a;
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		r = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(32'(a), 1'b1, d, rd);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		bus(32'(a), 1'b0, 32'h0, rd);
		check("register read", rd, exp);
	endtask
	task automatic wait_pins(input logic [3:0] exp);
		for (int n = 0; n < 16 && pwr_n !== exp; n++) @(negedge hclk);
		check("power pins", 32'(pwr_n), 32'(exp));
		@(posedge hclk);
	endtask
	task automatic do_reset(input logic c, input logic e, input logic s);
		@(posedge hclk);
		hresetn <= 1'b0;
		clock_rate_select <= c;
		external_memory_disable <= e;
		shared_power_select <= s;
		// pulse held for 20 edges here, though the logic resets asynchronously and needs no edge in reset
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
	endtask
	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		do_reset(1'b0, 1'b1, 1'b0);
		@(negedge hclk);
		check("pll enable", 32'(pll_enable), 32'h1);
		wait_pins(4'hf);
		rd_chk(OFS_CTRL, 32'(CTRL_RESET));
		rd_chk(OFS_EVENT, 32'(EVENT_RESET));
		rd_chk(OFS_MASK, 32'(MASK_RESET));
		rd_chk(OFS_CONFIG, 32'(CONFIG_RESET));
		rd_chk(OFS_STATE, st(1'b0, 1'b0, 1'b0, 4'h0));
		wr(8'h20, 32'hffffffff);
		rd_chk(8'h20, 32'h0);
		for (int k = 0; k < 4; k++) begin
			seed = lfsr(seed);
			wr(OFS_CTRL, {28'h0, seed[3:0]});
			wait_pins(~seed[3:0]);
			wr(OFS_MASK, {16'h0, seed});
			rd_chk(OFS_MASK, {27'h0, seed[4:0]});
		end
		wr(OFS_MASK, 32'h0);
		wr(OFS_CTRL, 32'hf);
		wait_pins(4'h0);
		spike[0] <= 1'b1;
		repeat (OCC - 1) @(posedge hclk);
		spike[0] <= 1'b0;
		repeat (12) @(negedge hclk);
		check("power pins", 32'(pwr_n), 32'h0);
		rd_chk(OFS_EVENT, 32'h0);
		fault[1] <= 1'b1;
		wait_pins(4'h2);
		rd_chk(OFS_EVENT, 32'h2);
		wr(OFS_MASK, 32'h1d);
		@(negedge hclk);
		check("irq", 32'(irq), 32'h0);
		wr(OFS_MASK, 32'h2);
		@(negedge hclk);
		check("irq", 32'(irq), 32'h1);
		@(posedge hclk);
		fault[1] <= 1'b0;
		wr(OFS_EVENT, 32'h2);
		@(negedge hclk);
		check("irq", 32'(irq), 32'h0);
		wait_pins(4'h0);
		fast_clock_input <= 1'b1;
		@(posedge hclk);
		fast_clock_input <= 1'b0;
		rd_chk(OFS_EVENT, 32'h10);
		wr(OFS_EVENT, 32'h10);
		for (int s = 1; s >= 0; s--) begin
			wr(OFS_CTRL, {27'h0, s[0], 4'hf});
			@(posedge hclk);
			@(negedge hclk);
			check("suspend", 32'(suspend_indicator), 32'(s[0]));
			rd_chk(OFS_STATE, st(1'b0, 1'b0, s[0], 4'hf));
		end
		do_reset(1'b1, 1'b1, 1'b1);
		repeat (8) @(posedge hclk) fast_clock_input <= ~fast_clock_input;
		@(negedge hclk);
		check("fast clock select", 32'(fast_clock_select), 32'h1);
		rd_chk(OFS_EVENT, 32'h0);
		rd_chk(OFS_STATE, st(1'b1, 1'b1, 1'b0, 4'h0));
		wr(OFS_CTRL, 32'h1);
		wait_pins(4'h0);
		fault[3] <= 1'b1;
		wait_pins(4'hf);
		rd_chk(OFS_EVENT, 32'hf);
		fault[3] <= 1'b0;
		do_reset(1'b0, 1'b0, 1'b1);
		rd_chk(OFS_STATE, st(1'b0, 1'b0, 1'b0, 4'h0));
		wr(OFS_CONFIG, 32'h1);
		rd_chk(OFS_STATE, st(1'b1, 1'b0, 1'b0, 4'h0));
		tally_and_finish;
	end
endmodule
